// File: include/rxbuf_pkg.sv
package rxbuf_pkg;
  // ==========================================================
  // Link and cell layout
  localparam int CELL_W = 8;
  localparam int TTO_W = 24;
  localparam int GAP_W = 16;
  localparam int BPC_W = 4;
  typedef enum logic [1:0] {KIND_L1, KIND_DP, KIND_CP} cell_kind_e;

  // ==========================================================
  // Memory sizes, in cells; dejitter cap in bits
  localparam int AW = 20;
  localparam logic [AW:0] TDI_FULL = 21'h088000;
  localparam logic [AW:0] TDI_LITE = 21'h040000;
  localparam logic [AW:0] FIFO_CELLS = 21'h000FA0;
  localparam int TDI_DEPTH = 561056;
  localparam logic [AW:0] ROOM_MARGIN = 21'h000040;
  localparam int BLKQ = 4;
  localparam int CB_CELLS = 16;
  localparam int CP_DEPTH = 32;
  localparam int DJB_W = 24;
  localparam logic [DJB_W-1:0] DJB_CAP = 24'h200000;

  // ==========================================================
  // Rates and times
  localparam longint CLK_HZ = 25000000;
  localparam longint RCELL_MAX = 7600000;
  localparam int CLK_NS = 40;
  // Elementary period of 7/64 us, held as ns x 64
  localparam int T_NS_X64 = 7000;
  localparam int CLK_NS_X64 = CLK_NS * 64;
  localparam logic [47:0] CB_COST = 48'(longint'(CB_CELLS) * CLK_HZ);
  localparam logic [TTO_W-1:0] TTO_RESET = 24'h000000;
endpackage : rxbuf_pkg

// File: include/rxbuf_link_if.sv
`timescale 1ns/10ps
interface rxbuf_link_if;
  logic cell_valid;
  logic cell_ready;
  logic [rxbuf_pkg::CELL_W-1:0] cell_data;
  rxbuf_pkg::cell_kind_e cell_kind;
  logic cell_last;
  logic frame_start;
  logic tto_valid;
  logic [rxbuf_pkg::TTO_W-1:0] time_to_output;
  logic [rxbuf_pkg::GAP_W-1:0] l1_gap;
  logic room;

  modport tx_mp (
    output cell_valid, cell_data, cell_kind, cell_last, frame_start,
    output tto_valid, time_to_output, l1_gap,
    input cell_ready, room
  );
  modport rx_mp (
    input cell_valid, cell_data, cell_kind, cell_last, frame_start,
    input tto_valid, time_to_output, l1_gap,
    output cell_ready, room
  );
endinterface : rxbuf_link_if

// File: core/rxbuf_tx_end.sv
`timescale 1ns/10ps
module rxbuf_tx_end (
  input wire logic core_clk,
  input wire logic nrst,
  rxbuf_link_if.tx_mp link,
  input wire logic src_valid,
  input wire logic [rxbuf_pkg::CELL_W-1:0] src_data,
  input wire rxbuf_pkg::cell_kind_e src_kind,
  input wire logic src_last,
  output logic src_ready,
  input wire logic frame_req,
  input wire logic [rxbuf_pkg::TTO_W-1:0] frame_tto,
  input wire logic tto_needed,
  input wire logic [rxbuf_pkg::GAP_W-1:0] l1_gap_in
);
  // ==========================================================
  // Cell forwarding, throttled by the receiver's room
  logic src_ready_r;
  logic valid_r;
  logic [rxbuf_pkg::CELL_W-1:0] data_r;
  rxbuf_pkg::cell_kind_e kind_r;
  logic last_r;
  logic frame_r;
  logic tto_valid_r;
  logic [rxbuf_pkg::TTO_W-1:0] tto_r;
  logic [rxbuf_pkg::GAP_W-1:0] gap_r;

  wire slot_free = !valid_r || link.cell_ready;
  wire take = src_valid && src_ready_r && slot_free;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      src_ready_r <= 1'b0;
      valid_r <= 1'b0;
      data_r <= '0;
      kind_r <= rxbuf_pkg::KIND_DP;
      last_r <= 1'b0;
    end else begin
      // Stop feeding before the far memory fills
      src_ready_r <= link.room && link.cell_ready;
      if (slot_free) begin
        valid_r <= take;
        data_r <= src_data;
        kind_r <= src_kind;
        last_r <= src_last;
      end
    end
  end

  // ==========================================================
  // Frame marker with output time in elementary periods
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_r <= 1'b0;
      tto_valid_r <= 1'b0;
      tto_r <= rxbuf_pkg::TTO_RESET;
      gap_r <= '0;
    end else begin
      frame_r <= frame_req;
      tto_valid_r <= frame_req && tto_needed;
      if (frame_req) begin
        tto_r <= frame_tto;
      end
      gap_r <= l1_gap_in;
    end
  end

  assign src_ready = src_ready_r;
  assign link.cell_valid = valid_r;
  assign link.cell_data = data_r;
  assign link.cell_kind = kind_r;
  assign link.cell_last = last_r;
  assign link.frame_start = frame_r;
  assign link.tto_valid = tto_valid_r;
  assign link.time_to_output = tto_r;
  assign link.l1_gap = gap_r;
endmodule : rxbuf_tx_end

// File: core/rxbuf_rx_end.sv
`timescale 1ns/10ps
// Operation
// - Sender keeps both buffers from over/underflow
// - Sender sends output time when rate varies
// - Output time counts from interleave frame start
// - Output time is in elementary sample periods
// - One decoder shared by pipes and signalling
// - Drain fast, capped at maximum cell rate
// - Signalling first; pipe block must finish before
// - Data and common pipes alternate strictly; code alternates only when both hold a block, else repeats the ready one
// - Decoder takes only whole code blocks
// - Dispatch only with dejitter room for bits
// - Deinterleaver memory size per profile
// - Single-pipe adds 4000-cell FIFO to capacity
// - Overflow when cells exceed memory locations
// - Overflow when three interleave blocks held
// - Overflow when write index passes read
// - Read block only after fully written
// - Add pipeline latency to output time
module rxbuf_rx_end #(
  parameter logic [rxbuf_pkg::TTO_W-1:0] LATENCY_T = 24'h000000
) (
  input wire logic core_clk,
  input wire logic nrst,
  rxbuf_link_if.rx_mp link,
  input wire logic reduced_profile,
  input wire logic single_pipe,
  input wire logic [31:0] lite_rate,
  input wire logic [rxbuf_pkg::BPC_W-1:0] bits_per_cell,
  input wire logic [31:0] out_rate,
  input wire logic status_clear,
  output logic dec_valid,
  output logic [rxbuf_pkg::CELL_W-1:0] dec_cell,
  output rxbuf_pkg::cell_kind_e dec_kind,
  output logic out_bit,
  output logic ovf_count,
  output logic ovf_blocks,
  output logic ovf_index,
  output logic underflow
);
  localparam int AW = rxbuf_pkg::AW;
  localparam int CB = rxbuf_pkg::CB_CELLS;

  // ==========================================================
  // Deinterleaver memory and block bookkeeping
  logic [rxbuf_pkg::CELL_W-1:0] tdi_mem [0:rxbuf_pkg::TDI_DEPTH-1];
  logic [rxbuf_pkg::CELL_W-1:0] cp_mem [0:rxbuf_pkg::CP_DEPTH-1];
  logic [AW:0] blk_len [0:rxbuf_pkg::BLKQ-1];
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [AW:0] tdi_cnt_r, open_cnt_r, rd_left_r;
  logic [2:0] cmp_cnt_r;
  logic [1:0] bq_wi_r, bq_ri_r;
  logic rd_active_r;
  logic [4:0] cp_wp_r, cp_rp_r;
  logic [5:0] cp_cnt_r;

  wire [AW:0] mem_size = (reduced_profile ? rxbuf_pkg::TDI_LITE
    : rxbuf_pkg::TDI_FULL)
    + (single_pipe ? rxbuf_pkg::FIFO_CELLS : '0);
  wire [AW-1:0] last_loc = AW'(mem_size - 1'b1);
  wire in_l1 = link.cell_valid && link.cell_kind == rxbuf_pkg::KIND_L1;
  wire in_dp = link.cell_valid && link.cell_kind == rxbuf_pkg::KIND_DP;
  wire in_cp = link.cell_valid && link.cell_kind == rxbuf_pkg::KIND_CP;
  wire blk_close = in_dp && link.cell_last;
  wire blk_open = !rd_active_r && cmp_cnt_r != 3'h0;
  wire [2:0] held = cmp_cnt_r + {2'h0, open_cnt_r != '0 || in_dp};

  // ==========================================================
  // Decoder arbitration and rate limit
  logic [4:0] dec_left_r;
  rxbuf_pkg::cell_kind_e src_r;
  logic rr_cp_r;
  logic [31:0] tok_r;
  wire [31:0] rate = (reduced_profile && lite_rate < 32'(rxbuf_pkg::RCELL_MAX))
    ? lite_rate : 32'(rxbuf_pkg::RCELL_MAX);
  wire has_tok = tok_r >= 32'(rxbuf_pkg::CLK_HZ);
  wire [47:0] gap_work = 48'(link.l1_gap) * 48'(rate);
  wire l1_safe = gap_work >= rxbuf_pkg::CB_COST;
  logic [rxbuf_pkg::DJB_W-1:0] djb_r;
  wire [rxbuf_pkg::DJB_W-1:0] blk_bits = rxbuf_pkg::DJB_W'(CB)
    * rxbuf_pkg::DJB_W'(bits_per_cell);
  wire djb_room = rxbuf_pkg::DJB_CAP - djb_r >= blk_bits;
  wire dp_ok = rd_active_r && rd_left_r >= (AW+1)'(CB);
  wire cp_ok = cp_cnt_r >= 6'(CB);
  wire can_start = dec_left_r == 5'h0 && !in_l1 && l1_safe && djb_room;
  wire grant_dp = can_start && dp_ok && (!cp_ok || rr_cp_r);
  wire grant_cp = can_start && cp_ok && (!dp_ok || !rr_cp_r);
  // Signalling cells pre-empt any pipe cell in that cycle
  wire move = dec_left_r != 5'h0 && has_tok && !in_l1;
  wire move_dp = move && src_r == rxbuf_pkg::KIND_DP;
  wire move_cp = move && src_r == rxbuf_pkg::KIND_CP;

  always_ff @(posedge core_clk) begin
    if (in_dp) begin
      tdi_mem[wr_ptr_r] <= link.cell_data;
    end
    if (in_cp) begin
      cp_mem[cp_wp_r] <= link.cell_data;
    end
    if (blk_close) begin
      blk_len[bq_wi_r] <= open_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      tdi_cnt_r <= '0;
      open_cnt_r <= '0;
      cmp_cnt_r <= 3'h0;
      bq_wi_r <= 2'h0;
      bq_ri_r <= 2'h0;
      rd_active_r <= 1'b0;
      rd_left_r <= '0;
    end else begin
      if (in_dp) begin
        wr_ptr_r <= wr_ptr_r == last_loc ? '0 : wr_ptr_r + 1'b1;
        open_cnt_r <= link.cell_last ? '0 : open_cnt_r + 1'b1;
      end
      if (move_dp) begin
        rd_ptr_r <= rd_ptr_r == last_loc ? '0 : rd_ptr_r + 1'b1;
      end
      tdi_cnt_r <= tdi_cnt_r + (AW+1)'(in_dp) - (AW+1)'(move_dp);
      if (blk_close) begin
        bq_wi_r <= bq_wi_r + 1'b1;
      end
      if (blk_open) begin
        rd_active_r <= 1'b1;
        rd_left_r <= blk_len[bq_ri_r];
      end else if (move_dp) begin
        rd_left_r <= rd_left_r - 1'b1;
        rd_active_r <= rd_left_r != (AW+1)'(1);
      end
      if (move_dp && rd_left_r == (AW+1)'(1)) begin
        bq_ri_r <= bq_ri_r + 1'b1;
      end
      cmp_cnt_r <= cmp_cnt_r + 3'(blk_close)
        - 3'(move_dp && rd_left_r == (AW+1)'(1));
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cp_wp_r <= 5'h0;
      cp_rp_r <= 5'h0;
      cp_cnt_r <= 6'h0;
      dec_left_r <= 5'h0;
      src_r <= rxbuf_pkg::KIND_DP;
      rr_cp_r <= 1'b0;
      tok_r <= '0;
    end else begin
      cp_wp_r <= cp_wp_r + 5'(in_cp);
      cp_rp_r <= cp_rp_r + 5'(move_cp);
      cp_cnt_r <= cp_cnt_r + 6'(in_cp) - 6'(move_cp);
      if (grant_dp || grant_cp) begin
        dec_left_r <= 5'(CB);
        src_r <= grant_cp ? rxbuf_pkg::KIND_CP : rxbuf_pkg::KIND_DP;
        rr_cp_r <= grant_cp;
      end else if (move) begin
        dec_left_r <= dec_left_r - 1'b1;
      end
      // One cell banked at most, so no burst beats the cap
      if (move) begin
        tok_r <= tok_r - 32'(rxbuf_pkg::CLK_HZ) + rate;
      end else if (!has_tok) begin
        tok_r <= tok_r + rate;
      end
    end
  end

  // ==========================================================
  // Dejitter buffer and timed output
  logic [rxbuf_pkg::TTO_W-1:0] tto_cnt_r;
  logic [15:0] t_acc_r;
  logic [31:0] o_acc_r;
  logic out_en_r;
  wire t_tick = t_acc_r + 16'(rxbuf_pkg::CLK_NS_X64)
    >= 16'(rxbuf_pkg::T_NS_X64);
  wire due = out_en_r && o_acc_r >= 32'(rxbuf_pkg::CLK_HZ);
  wire emit = due && djb_r != '0;
  wire [rxbuf_pkg::DJB_W-1:0] djb_add = move
    ? rxbuf_pkg::DJB_W'(bits_per_cell) : '0;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      djb_r <= '0;
      tto_cnt_r <= rxbuf_pkg::TTO_RESET;
      t_acc_r <= 16'h0000;
      o_acc_r <= '0;
      out_en_r <= 1'b0;
    end else begin
      djb_r <= djb_r + djb_add - rxbuf_pkg::DJB_W'(emit);
      t_acc_r <= t_tick
        ? 16'(t_acc_r + 16'(rxbuf_pkg::CLK_NS_X64)
          - 16'(rxbuf_pkg::T_NS_X64))
        : 16'(t_acc_r + 16'(rxbuf_pkg::CLK_NS_X64));
      o_acc_r <= due ? o_acc_r - 32'(rxbuf_pkg::CLK_HZ) + out_rate
        : (out_en_r ? o_acc_r + out_rate : '0);
      if (link.frame_start && link.tto_valid) begin
        tto_cnt_r <= link.time_to_output + LATENCY_T;
        out_en_r <= 1'b0;
      end else if (link.frame_start && !out_en_r && tto_cnt_r == '0) begin
        out_en_r <= 1'b1; // Self-balancing start without a time
      end else if (tto_cnt_r != '0) begin
        if (t_tick) begin
          tto_cnt_r <= tto_cnt_r - 1'b1;
          out_en_r <= tto_cnt_r == 24'h000001;
        end
      end
    end
  end

  // ==========================================================
  // Outputs and sticky status
  logic dec_valid_r, out_bit_r;
  logic [rxbuf_pkg::CELL_W-1:0] dec_cell_r;
  rxbuf_pkg::cell_kind_e dec_kind_r;
  logic ovf_count_r, ovf_blocks_r, ovf_index_r, underflow_r;
  logic ready_r, room_r;
  wire set_count = in_dp && tdi_cnt_r >= mem_size;
  wire set_blocks = held > 3'h2;
  wire set_index = in_dp && tdi_cnt_r != '0 && wr_ptr_r == rd_ptr_r
    && !move_dp;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dec_valid_r <= 1'b0;
      dec_cell_r <= '0;
      dec_kind_r <= rxbuf_pkg::KIND_L1;
      out_bit_r <= 1'b0;
      ovf_count_r <= 1'b0;
      ovf_blocks_r <= 1'b0;
      ovf_index_r <= 1'b0;
      underflow_r <= 1'b0;
      ready_r <= 1'b0;
      room_r <= 1'b0;
    end else begin
      dec_valid_r <= in_l1 || move;
      dec_kind_r <= in_l1 ? rxbuf_pkg::KIND_L1 : src_r;
      dec_cell_r <= in_l1 ? link.cell_data
        : (move_cp ? cp_mem[cp_rp_r] : tdi_mem[rd_ptr_r]);
      out_bit_r <= emit;
      // Set beats a clear in the same cycle
      ovf_count_r <= set_count || (ovf_count_r && !status_clear);
      ovf_blocks_r <= set_blocks || (ovf_blocks_r && !status_clear);
      ovf_index_r <= set_index || (ovf_index_r && !status_clear);
      underflow_r <= (due && djb_r == '0)
        || (underflow_r && !status_clear);
      ready_r <= 1'b1;
      room_r <= tdi_cnt_r + rxbuf_pkg::ROOM_MARGIN < mem_size
        && cp_cnt_r < 6'(rxbuf_pkg::CP_DEPTH - 4);
    end
  end

  assign link.cell_ready = ready_r;
  assign link.room = room_r;
  assign dec_valid = dec_valid_r;
  assign dec_cell = dec_cell_r;
  assign dec_kind = dec_kind_r;
  assign out_bit = out_bit_r;
  assign ovf_count = ovf_count_r;
  assign ovf_blocks = ovf_blocks_r;
  assign ovf_index = ovf_index_r;
  assign underflow = underflow_r;
endmodule : rxbuf_rx_end

// File: test/rxbuf_link_props.sv
`timescale 1ns/10ps
module rxbuf_link_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cell_valid,
  input wire logic cell_ready,
  input wire logic [rxbuf_pkg::CELL_W-1:0] cell_data,
  input wire rxbuf_pkg::cell_kind_e cell_kind,
  input wire logic cell_last,
  input wire logic frame_start,
  input wire logic tto_valid,
  input wire logic [rxbuf_pkg::TTO_W-1:0] time_to_output,
  input wire logic [rxbuf_pkg::GAP_W-1:0] l1_gap,
  input wire logic room
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==========
  // Framing
  tto_frame_a: assert property (tto_valid |-> frame_start)
    else $error("output time outside frame start");
  frame_pulse_a: assert property (frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
  tto_pulse_a: assert property (tto_valid |=> !tto_valid)
    else $error("output time valid longer than one cycle");
  // ==========
  // Cell flow
  ready_up_a: assert property (!cell_ready |=> cell_ready)
    else $error("cell ready not restored");
  stall_hold_a: assert property (cell_valid && !cell_ready
    |=> cell_valid && $stable(cell_data))
    else $error("stalled cell changed");
  // Room reaches the sender's cell flop through two stages
  room_gate_a: assert property (!$past(room, 2) |-> !cell_valid)
    else $error("cell sent without room");
  last_dp_a: assert property (cell_valid && cell_last
    |-> cell_kind == rxbuf_pkg::KIND_DP)
    else $error("block end on a non data pipe cell");
  kind_ok_a: assert property (cell_valid |-> cell_kind inside
    {rxbuf_pkg::KIND_L1, rxbuf_pkg::KIND_DP, rxbuf_pkg::KIND_CP})
    else $error("illegal cell kind");
  cover property (cell_valid && cell_kind == rxbuf_pkg::KIND_L1);
  cover property (cell_valid && cell_last);
  cover property (tto_valid && time_to_output != 24'h000000);
  cover property (cell_valid && l1_gap < 16'h0010);
endmodule : rxbuf_link_props

// File: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam int LAT = 16;
  logic core_clk, nrst, src_valid, src_last, src_ready, frame_req;
  logic tto_needed, reduced_profile, single_pipe, status_clear;
  logic [7:0] src_data, dec_cell;
  rxbuf_pkg::cell_kind_e src_kind, dec_kind;
  logic [23:0] frame_tto;
  logic [15:0] l1_gap_in;
  logic [31:0] lite_rate, out_rate;
  logic [3:0] bits_per_cell;
  logic dec_valid, out_bit, ovf_count, ovf_blocks, ovf_index, underflow;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int last_mv = -1000;
  int min_gap = 1000;
  rxbuf_pkg::cell_kind_e kq[$];
  logic [7:0] l1q[$];
  logic [7:0] dq[$];

  rxbuf_link_if link();
  rxbuf_tx_end u_rxbuf_tx_end (.core_clk, .nrst, .link(link), .src_valid,
    .src_data, .src_kind, .src_last, .src_ready, .frame_req, .frame_tto,
    .tto_needed, .l1_gap_in);
  rxbuf_rx_end #(.LATENCY_T(24'h000010)) u_rxbuf_rx_end (.core_clk, .nrst,
    .link(link), .reduced_profile, .single_pipe, .lite_rate,
    .bits_per_cell, .out_rate, .status_clear, .dec_valid, .dec_cell,
    .dec_kind, .out_bit, .ovf_count, .ovf_blocks, .ovf_index, .underflow);
  rxbuf_link_props u_props (.core_clk, .nrst,
    .cell_valid(link.cell_valid), .cell_ready(link.cell_ready),
    .cell_data(link.cell_data), .cell_kind(link.cell_kind),
    .cell_last(link.cell_last), .frame_start(link.frame_start),
    .tto_valid(link.tto_valid), .time_to_output(link.time_to_output), .l1_gap(link.l1_gap),
    .room(link.room));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ==========
  // Decoder monitor
  always @(posedge core_clk) begin
    cyc++;
    if (dec_valid === 1'b1) begin
      if (dec_kind === rxbuf_pkg::KIND_L1) l1q.push_back(dec_cell);
      else begin
        kq.push_back(dec_kind);
        dq.push_back(dec_cell);
        if (cyc - last_mv < min_gap) min_gap = cyc - last_mv;
        last_mv = cyc;
      end
    end
  end

  // ==========
  // Helpers
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %0h, want %0h", $time, seen, exp);
    end
  endtask : check

  task automatic hung(input int k, input int lim);
    if (k >= lim) begin
      failures++;
      $display("Error at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask : hung

  task automatic send(input rxbuf_pkg::cell_kind_e k, input logic [7:0] d,
      input logic l);
    int n;
    n = 0;
    src_valid <= 1'b1;
    src_kind <= k;
    src_data <= d;
    src_last <= l;
    do begin
      @(posedge core_clk);
      n++;
    end while (src_ready !== 1'b1 && n < 50);
    hung(n, 50);
  endtask : send

  task automatic idle;
    src_valid <= 1'b0;
    src_last <= 1'b0;
    @(posedge core_clk);
  endtask : idle

  // Whole block only; tail cells below 16 never dispatch
  task automatic block(input rxbuf_pkg::cell_kind_e k, input logic [7:0] b);
    for (int i = 0; i < 16; i++)
      send(k, b + 8'(i), k == rxbuf_pkg::KIND_DP && i == 15);
  endtask : block

  task automatic wait_q(input int n);
    int k;
    k = 0;
    while (kq.size() < n && k < 5000) begin
      @(posedge core_clk);
      k++;
    end
    hung(k, 5000);
  endtask : wait_q

  // ==========
  // Scenarios
  task automatic s_l1;
    l1q = {};
    send(rxbuf_pkg::KIND_L1, 8'hA5, 1'b0);
    idle();
    repeat (6) @(posedge core_clk);
    check(l1q.size(), 1);
    if (l1q.size() > 0) check(l1q[0], 8'hA5);
  endtask : s_l1

  task automatic s_dispatch(input logic lite, input int gap);
    reduced_profile <= lite;
    kq = {};
    dq = {};
    min_gap = 1000;
    block(rxbuf_pkg::KIND_CP, 8'h40);
    block(rxbuf_pkg::KIND_CP, 8'h50);
    block(rxbuf_pkg::KIND_DP, 8'h80);
    block(rxbuf_pkg::KIND_DP, 8'h90);
    idle();
    wait_q(64);
    for (int i = 0; i < 64; i++) begin
      check(kq[i], (i / 16) % 2 ? rxbuf_pkg::KIND_DP
        : rxbuf_pkg::KIND_CP);
      check(dq[i], 8'h40 + 8'((i / 16) % 2 * 64
        + i / 32 * 16 + i % 16));
    end
    check(min_gap >= gap, 1);
  endtask : s_dispatch

  task automatic s_l1_first;
    l1_gap_in <= 16'h000A;
    kq = {};
    dq = {};
    block(rxbuf_pkg::KIND_CP, 8'h60);
    idle();
    repeat (200) @(posedge core_clk);
    check(kq.size(), 0);
    l1_gap_in <= 16'hFFFF;
    wait_q(16);
    check(kq.size(), 16);
    check(dq[15], 8'h6F);
  endtask : s_l1_first

  task automatic s_output;
    int k, lo;
    lo = (256 + LAT) * rxbuf_pkg::T_NS_X64 / rxbuf_pkg::CLK_NS_X64;
    k = 0;
    out_rate <= 32'h00BEBC20;
    tto_needed <= 1'b1;
    frame_tto <= 24'h000100;
    frame_req <= 1'b1;
    @(posedge core_clk);
    frame_req <= 1'b0;
    while (out_bit !== 1'b1 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    check(k >= lo && k <= lo + 8, 1);
    repeat (3000) @(posedge core_clk);
    check(underflow, 1);
    out_rate <= 32'h00000000;
    status_clear <= 1'b1;
    repeat (2) @(posedge core_clk);
    status_clear <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(underflow, 0);
    check({ovf_count, ovf_index, ovf_blocks}, 0);
    // Steady rate: frame marker goes out without an output time
    tto_needed <= 1'b0;
    frame_req <= 1'b1;
    @(posedge core_clk);
    frame_req <= 1'b0;
    @(posedge core_clk);
    check({link.frame_start, link.tto_valid}, 2'b10);
  endtask : s_output

  task automatic s_blocks;
    l1_gap_in <= 16'h000A;
    block(rxbuf_pkg::KIND_DP, 8'h10);
    block(rxbuf_pkg::KIND_DP, 8'h20);
    idle();
    repeat (3) @(posedge core_clk);
    check(ovf_blocks, 0);
    send(rxbuf_pkg::KIND_DP, 8'h30, 1'b0);
    idle();
    repeat (3) @(posedge core_clk);
    check(ovf_blocks, 1);
  endtask : s_blocks

  initial begin
    nrst = 1'b0;
    {src_valid, src_last, frame_req, tto_needed} = 4'h0;
    {reduced_profile, single_pipe, status_clear} = 3'h0;
    src_data = 8'h00;
    src_kind = rxbuf_pkg::KIND_DP;
    frame_tto = 24'h000000;
    l1_gap_in = 16'hFFFF;
    lite_rate = 32'h002625A0;
    out_rate = 32'h00000000;
    bits_per_cell = 4'h4;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(link.cell_ready, 1);
    check(underflow, 0);
    s_l1();
    s_dispatch(1'b0, 3);
    s_dispatch(1'b1, 10);
    s_l1_first();
    s_output();
    s_blocks();
    report_and_stop();
  end
endmodule : testbench
